// [verilog/pnlpc_top.sv]
`include "pnlpc_defs.svh"
`default_nettype none
module pnlpc_top #(
	parameter int SEQ_DIV = `PNLPC_SEQ_DIV
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	input wire logic standby_pin_n,
	input wire logic threshold_strap_pin,
	input wire logic clk32_pin,
	input wire logic general_io_one_pin,
	input wire logic seq_clk_32k_sel,
	input wire logic dac_enabled,
	input wire logic text_mode,
	input wire logic [1:0] misc_sync_pol,
	input wire logic general_io_one_out,
	input wire pnlpc_pkg::pnlpc_sig_t sig_in,
	output pnlpc_pkg::pnlpc_pins_t pins,
	output logic general_io_one_in,
	output logic [7:0] output_drive_control,
	output logic host_standby,
	output logic [2:0] refresh_per_line,
	output logic screen_refresh_en,
	output logic palette_powerdown,
	output logic palette_cpu_access,
	output logic standby_refresh_req
);
	logic [7:0] io_index;
	logic [7:0] display_select_reg;
	logic [7:0] panel_power_delay;
	logic [7:0] power_down_control;
	logic [7:0] panel_power_down_options;
	logic [7:0] panel_pin_polarity;
	logic [7:0] panel_pin_routing;
	logic [7:0] pin_function_control;
	logic [3:0] pin_s;
	logic stby_q;
	logic c32_q;
	logic [10:0] div_cnt;
	logic div_tick;
	logic [1:0] strap_cnt;
	logic seq_powered;
	logic seq_live;
	logic cpu_ok;
	logic wr_data;
	logic stby_rise;
	logic seq_tick;
	logic standby_active;
	logic panel_off;
	logic quiet;
	logic seq_req;
	logic [1:0] sync_pol;
	logic hs;
	logic vs;
	logic cs;
	logic de;
	logic sync_kill;
	logic bias;
	logic bkl;
	logic [7:0] next_rdata;
	pnlpc_pkg::pnlpc_disp_t mode;
	pnlpc_pkg::pnlpc_bkl_t bkl_role;
	pnlpc_pkg::pnlpc_pins_t next_pins;

	// ***************************
	// Pin synchronisers and clocking
	// ***************************
	// Standby enters inverted so the flop reset matches its idle level: no false edge
	pnlpc_sync #(
		.W(4)
	) u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.d({~standby_pin_n, threshold_strap_pin, clk32_pin, general_io_one_pin}),
		.q(pin_s)
	);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stby_q <= 1'b0;
			c32_q <= 1'b0;
		end else begin
			stby_q <= pin_s[3];
			c32_q <= pin_s[1];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= 11'h000;
			div_tick <= 1'b0;
		end else begin
			div_tick <= (div_cnt == 11'(SEQ_DIV - 1));
			div_cnt <= (div_cnt == 11'(SEQ_DIV - 1)) ? 11'h000 : div_cnt + 11'h001;
		end
	end

	// External 32 kHz source scales every delay in proportion
	assign seq_tick = seq_clk_32k_sel ? (pin_s[1] & ~c32_q) : div_tick;
	assign stby_rise = stby_q & ~pin_s[3];
	assign standby_active = pin_s[3];
	assign cpu_ok = ~power_down_control[`PNLPC_B_HOST_STBY];
	assign wr_data = io_wr && cpu_ok && io_addr == `PNLPC_IO_DATA;
	assign mode = pnlpc_pkg::pnlpc_disp_t'(display_select_reg[1:0]);
	assign panel_off = power_down_control[`PNLPC_B_PANEL_OFF];
	assign quiet = panel_off || standby_active;
	assign seq_req = (mode == pnlpc_pkg::PNLPC_DISP_PANEL) && !quiet;
	assign bkl_role = pnlpc_pkg::pnlpc_bkl_t'(pin_function_control[7:6]);

	pnlpc_seq u_seq (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.tick(seq_tick),
		.req(seq_req),
		.up_dly(panel_power_delay[7:4]),
		.dn_dly(panel_power_delay[3:0]),
		.powered(seq_powered),
		.live(seq_live)
	);

	// ***************************
	// Register file
	// ***************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			io_index <= `PNLPC_RST_ZERO;
		end else if (io_wr && cpu_ok && io_addr == `PNLPC_IO_INDEX) begin
			io_index <= io_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			display_select_reg <= `PNLPC_RST_DISP_SEL;
			panel_power_delay <= `PNLPC_RST_PWR_DLY;
			panel_power_down_options <= `PNLPC_RST_ZERO;
			panel_pin_polarity <= `PNLPC_RST_ZERO;
			panel_pin_routing <= `PNLPC_RST_ZERO;
			pin_function_control <= `PNLPC_RST_ZERO;
		end else if (wr_data) begin
			case (io_index)
				`PNLPC_IDX_DISP_SEL: display_select_reg <= io_wdata;
				`PNLPC_IDX_PWR_DLY: panel_power_delay <= io_wdata;
				`PNLPC_IDX_PDN_OPT: panel_power_down_options <= io_wdata & `PNLPC_PDN_OPT_MASK;
				`PNLPC_IDX_PIN_POL: panel_pin_polarity <= io_wdata;
				`PNLPC_IDX_PIN_RTE: panel_pin_routing <= io_wdata;
				`PNLPC_IDX_PIN_FN: pin_function_control <= io_wdata;
				default: ;
			endcase
		end
	end

	// Pin release of standby wins over a same-cycle write setting it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			power_down_control <= `PNLPC_RST_PDN_CTL;
		end else if (stby_rise) begin
			power_down_control[`PNLPC_B_HOST_STBY] <= 1'b0;
		end else if (wr_data && io_index == `PNLPC_IDX_PDN_CTL) begin
			power_down_control <= io_wdata;
		end
	end

	// Strap is sampled once the synchroniser holds a settled value
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			strap_cnt <= 2'h0;
			output_drive_control <= `PNLPC_RST_ZERO;
		end else if (strap_cnt != `PNLPC_STRAP_WAIT) begin
			strap_cnt <= strap_cnt + 2'h1;
			output_drive_control[`PNLPC_B_THRESH] <= pin_s[2];
		end else if (wr_data && io_index == `PNLPC_IDX_DRV_CTL) begin
			output_drive_control <= io_wdata;
		end
	end

	always_comb begin
		case (io_index)
			`PNLPC_IDX_DISP_SEL: next_rdata = display_select_reg;
			`PNLPC_IDX_PWR_DLY: next_rdata = panel_power_delay;
			`PNLPC_IDX_PDN_CTL: next_rdata = power_down_control;
			`PNLPC_IDX_PDN_OPT: next_rdata = panel_power_down_options;
			`PNLPC_IDX_PIN_POL: next_rdata = panel_pin_polarity;
			`PNLPC_IDX_DRV_CTL: next_rdata = output_drive_control;
			`PNLPC_IDX_PIN_RTE: next_rdata = panel_pin_routing;
			`PNLPC_IDX_PIN_FN: next_rdata = pin_function_control;
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			io_rdata <= 8'h00;
		end else if (io_rd && cpu_ok) begin
			io_rdata <= (io_addr == `PNLPC_IO_INDEX) ? io_index :
				(io_addr == `PNLPC_IO_DATA) ? next_rdata : 8'h00;
		end
	end

	// ***************************
	// Sync and panel signal shaping
	// ***************************
	always_comb begin
		sync_pol = (mode == pnlpc_pkg::PNLPC_DISP_CRT) ? misc_sync_pol :
			panel_pin_polarity[7:6];
		hs = sig_in.crt_hsync ^ sync_pol[0];
		vs = sig_in.crt_vsync ^ sync_pol[1];
		cs = (sig_in.crt_hsync | sig_in.crt_vsync) ^ sync_pol[0];
		de = sig_in.disp_en ^ panel_pin_polarity[1];
		sync_kill = (!dac_enabled && !panel_power_down_options[`PNLPC_B_SYNC_KEEP]) ||
			panel_off || (mode == pnlpc_pkg::PNLPC_DISP_PANEL && quiet);
		bias = seq_powered;
		bkl = seq_powered;
		next_pins = '0;
		next_pins.mem_c_oe = !panel_pin_routing[`PNLPC_B_MEMC_TRI];
		next_pins.video_invert = text_mode ? panel_pin_polarity[4] :
			panel_pin_polarity[5];
		if (sync_kill) begin
			next_pins.hsync_out = 1'b0;
			next_pins.vsync_out = 1'b0;
			cs = 1'b0;
		end else if (panel_pin_routing[`PNLPC_B_COMP_SYNC]) begin
			next_pins.hsync_out = cs;
			next_pins.vsync_out = vs;
		end else begin
			next_pins.hsync_out = panel_pin_routing[`PNLPC_B_SIMPLE_CS] ? cs : hs;
			next_pins.vsync_out = vs;
		end
		// Live covers the power-down delay, so panel signals outlast the request
		if (seq_live) begin
			next_pins.panel_oe = 1'b1;
			next_pins.frame_marker_out = sig_in.frame_marker ^ panel_pin_polarity[3];
			next_pins.line_pulse_out = panel_pin_routing[`PNLPC_B_LP_DE] ? de :
				sig_in.line_pulse ^ panel_pin_polarity[2];
			next_pins.ac_mod_out = panel_pin_routing[`PNLPC_B_AC_DE] ? de : sig_in.ac_mod;
		end else if ((mode == pnlpc_pkg::PNLPC_DISP_PANEL &&
			!power_down_control[`PNLPC_B_QUIET_TRI]) ||
			(mode != pnlpc_pkg::PNLPC_DISP_PANEL &&
			power_down_control[`PNLPC_B_CRT_DRIVE])) begin
			// Driven inactive: idle level follows each programmed polarity
			next_pins.panel_oe = 1'b1;
			next_pins.frame_marker_out = panel_pin_polarity[3];
			next_pins.line_pulse_out = panel_pin_routing[`PNLPC_B_LP_DE] ?
				panel_pin_polarity[1] : panel_pin_polarity[2];
			next_pins.ac_mod_out = panel_pin_routing[`PNLPC_B_AC_DE] & panel_pin_polarity[1];
		end else begin
			next_pins.panel_pulldown = 1'b1;
		end
		next_pins.pin61_out = panel_pin_routing[`PNLPC_B_SWAP_BIAS] ? bkl : bias;
		next_pins.pin54_oe = 1'b1;
		case (bkl_role)
			pnlpc_pkg::PNLPC_BKL_ENABLE:
				next_pins.pin54_out = panel_pin_routing[`PNLPC_B_SWAP_BIAS] ? bias : bkl;
			pnlpc_pkg::PNLPC_BKL_COMPOSITE_SYNC_OUT: next_pins.pin54_out = cs;
			pnlpc_pkg::PNLPC_BKL_GPIN: next_pins.pin54_oe = 1'b0;
			pnlpc_pkg::PNLPC_BKL_GPOUT: next_pins.pin54_out = general_io_one_out;
			default: next_pins.pin54_out = 1'b0;
		endcase
	end

	// ***************************
	// Output flops
	// ***************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pins <= '0;
			general_io_one_in <= 1'b0;
		end else begin
			pins <= next_pins;
			if (bkl_role == pnlpc_pkg::PNLPC_BKL_GPIN) begin
				general_io_one_in <= pin_s[0];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			screen_refresh_en <= 1'b0;
			palette_powerdown <= 1'b0;
			palette_cpu_access <= 1'b1;
			standby_refresh_req <= 1'b0;
		end else begin
			screen_refresh_en <= !panel_off && mode != pnlpc_pkg::PNLPC_DISP_OFF;
			palette_powerdown <= panel_off &&
				panel_power_down_options[`PNLPC_B_PAL_PDN];
			palette_cpu_access <= !(panel_off && panel_power_down_options[`PNLPC_B_PAL_PDN]) ||
				panel_power_down_options[`PNLPC_B_PAL_ACC];
			standby_refresh_req <= standby_active && seq_tick &&
				power_down_control[`PNLPC_B_STBY_RFSH];
		end
	end

	assign host_standby = power_down_control[`PNLPC_B_HOST_STBY];
	assign refresh_per_line = power_down_control[2:0];

	// ***************************
	// Checks
	// ***************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	property p_hstby_block;
		(host_standby && !stby_rise && io_wr) |=> $stable(panel_pin_routing) && $stable(io_index);
	endproperty
	a_hstby_block: assert property (p_hstby_block) else $error("write taken in standby");

	property p_hstby_clear;
		stby_rise |=> !host_standby;
	endproperty
	a_hstby_clear: assert property (p_hstby_clear) else $error("standby not cleared");

	property p_tick_gap;
		div_tick |-> div_cnt == 11'h000 && $past(div_cnt) == 11'(SEQ_DIV - 1);
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("tick too frequent");

	property p_crt_tri;
		(mode == pnlpc_pkg::PNLPC_DISP_CRT && !power_down_control[7] && !seq_live) |=>
			!pins.panel_oe && pins.panel_pulldown;
	endproperty
	a_crt_tri: assert property (p_crt_tri) else $error("panel not tri-stated");

	property p_off_refresh;
		panel_off |=> !screen_refresh_en;
	endproperty
	a_off_refresh: assert property (p_off_refresh) else $error("refresh during panel off");

	property p_gpin;
		(bkl_role == pnlpc_pkg::PNLPC_BKL_GPIN) |=> !pins.pin54_oe;
	endproperty
	a_gpin: assert property (p_gpin) else $error("input pin driven");

	property p_composite_sync_out;
		(panel_pin_routing[2] && !sync_kill && sig_in.crt_vsync && !sync_pol[0]) |=>
			pins.hsync_out;
	endproperty
	a_composite_sync_out: assert property (p_composite_sync_out) else $error("composite sync missing");

	property p_kill;
		(!dac_enabled && !panel_power_down_options[2]) |=> !pins.hsync_out && !pins.vsync_out;
	endproperty
	a_kill: assert property (p_kill) else $error("sync active with dac off");

	property p_palette;
		!panel_off |=> !palette_powerdown && palette_cpu_access;
	endproperty
	a_palette: assert property (p_palette) else $error("palette wrongly down");

	c_stby_clear: cover property (host_standby ##1 !host_standby);
	c_panel_on: cover property (seq_req ##1 pins.panel_oe);
	c_panel_off: cover property ($rose(panel_off));
endmodule
`default_nettype wire

// [shared/pnlpc_defs.svh]
`ifndef PNLPC_DEFS_SVH
`define PNLPC_DEFS_SVH

// ***************************
// Timing
// ***************************
`define PNLPC_CLK_HZ 40000000
`define PNLPC_SEQ_HZ 37500
`define PNLPC_SEQ_DIV ((`PNLPC_CLK_HZ + `PNLPC_SEQ_HZ - 1) / `PNLPC_SEQ_HZ)
`define PNLPC_UP_STEP_US 3400
`define PNLPC_DN_STEP_US 29000
`define PNLPC_UP_STEP ((`PNLPC_UP_STEP_US * `PNLPC_SEQ_HZ + 999999) / 1000000)
`define PNLPC_DN_STEP ((`PNLPC_DN_STEP_US * `PNLPC_SEQ_HZ + 999999) / 1000000)

// ***************************
// Ports and indices
// ***************************
`define PNLPC_IO_INDEX 16'h03d0
`define PNLPC_IO_DATA 16'h03d1
`define PNLPC_IDX_DISP_SEL 8'h01
`define PNLPC_IDX_PWR_DLY 8'h04
`define PNLPC_IDX_PDN_CTL 8'h05
`define PNLPC_IDX_PDN_OPT 8'h06
`define PNLPC_IDX_PIN_POL 8'h08
`define PNLPC_IDX_DRV_CTL 8'h0a
`define PNLPC_IDX_PIN_RTE 8'h0b
`define PNLPC_IDX_PIN_FN 8'h0c

// ***************************
// Reset values and fields
// ***************************
`define PNLPC_RST_DISP_SEL 8'h01
`define PNLPC_RST_PWR_DLY 8'h81
`define PNLPC_RST_PDN_CTL 8'h01
`define PNLPC_RST_ZERO 8'h00
`define PNLPC_PDN_OPT_MASK 8'h07
`define PNLPC_B_CRT_DRIVE 7
`define PNLPC_B_STBY_RFSH 6
`define PNLPC_B_QUIET_TRI 5
`define PNLPC_B_HOST_STBY 4
`define PNLPC_B_PANEL_OFF 3
`define PNLPC_B_SYNC_KEEP 2
`define PNLPC_B_PAL_ACC 1
`define PNLPC_B_PAL_PDN 0
`define PNLPC_B_THRESH 1
`define PNLPC_B_MEMC_TRI 7
`define PNLPC_B_SIMPLE_CS 5
`define PNLPC_B_SWAP_BIAS 3
`define PNLPC_B_COMP_SYNC 2
`define PNLPC_B_LP_DE 1
`define PNLPC_B_AC_DE 0
`define PNLPC_STRAP_WAIT 2'h3

`endif

// [shared/pnlpc_pkg.sv]
`default_nettype none
package pnlpc_pkg;
	typedef enum logic [1:0] {
		PNLPC_DISP_OFF = 2'b00,
		PNLPC_DISP_CRT = 2'b01,
		PNLPC_DISP_PANEL = 2'b10,
		PNLPC_DISP_RSVD = 2'b11
	} pnlpc_disp_t;

	typedef enum logic [1:0] {
		PNLPC_BKL_ENABLE = 2'b00,
		PNLPC_BKL_COMPOSITE_SYNC_OUT = 2'b01,
		PNLPC_BKL_GPIN = 2'b10,
		PNLPC_BKL_GPOUT = 2'b11
	} pnlpc_bkl_t;

	typedef enum logic [1:0] {
		PNLPC_SEQ_OFF = 2'b00,
		PNLPC_SEQ_UP = 2'b01,
		PNLPC_SEQ_ON = 2'b10,
		PNLPC_SEQ_DOWN = 2'b11
	} pnlpc_seq_t;

	typedef struct packed {
		logic crt_hsync;
		logic crt_vsync;
		logic frame_marker;
		logic line_pulse;
		logic ac_mod;
		logic disp_en;
	} pnlpc_sig_t;

	typedef struct packed {
		logic hsync_out;
		logic vsync_out;
		logic frame_marker_out;
		logic line_pulse_out;
		logic ac_mod_out;
		logic pin61_out;
		logic pin54_out;
		logic pin54_oe;
		logic panel_oe;
		logic panel_pulldown;
		logic mem_c_oe;
		logic video_invert;
	} pnlpc_pins_t;
endpackage
`default_nettype wire

// [verilog/pnlpc_sync.sv]
`default_nettype none
module pnlpc_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule
`default_nettype wire

// [verilog/pnlpc_seq.sv]
`include "pnlpc_defs.svh"
`default_nettype none
module pnlpc_seq #(
	parameter int UP_STEP = `PNLPC_UP_STEP,
	parameter int DN_STEP = `PNLPC_DN_STEP
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic req,
	input wire logic [3:0] up_dly,
	input wire logic [3:0] dn_dly,
	output logic powered,
	output logic live
);
	pnlpc_pkg::pnlpc_seq_t state;
	logic [13:0] cnt;
	logic [13:0] target;

	// ***************************
	// Sequencer
	// ***************************
	// Delay is latched on entering power-up and power-down so a rewrite cannot cut one short
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= pnlpc_pkg::PNLPC_SEQ_OFF;
			cnt <= 14'h0000;
			target <= 14'h0000;
			powered <= 1'b0;
			live <= 1'b0;
		end else begin
			case (state)
				pnlpc_pkg::PNLPC_SEQ_OFF: begin
					if (req) begin
						state <= pnlpc_pkg::PNLPC_SEQ_UP;
						cnt <= 14'h0000;
						target <= 14'(up_dly * UP_STEP);
						live <= 1'b1;
					end
				end
				pnlpc_pkg::PNLPC_SEQ_UP: begin
					if (!req) begin
						state <= pnlpc_pkg::PNLPC_SEQ_OFF;
						live <= 1'b0;
					end else if (cnt >= target) begin
						state <= pnlpc_pkg::PNLPC_SEQ_ON;
						powered <= 1'b1;
					end else if (tick) begin
						cnt <= cnt + 14'h0001;
					end
				end
				pnlpc_pkg::PNLPC_SEQ_ON: begin
					if (!req) begin
						state <= pnlpc_pkg::PNLPC_SEQ_DOWN;
						cnt <= 14'h0000;
						target <= 14'(dn_dly * DN_STEP);
						powered <= 1'b0;
					end
				end
				pnlpc_pkg::PNLPC_SEQ_DOWN: begin
					if (cnt >= target) begin
						state <= pnlpc_pkg::PNLPC_SEQ_OFF;
						live <= 1'b0;
					end else if (tick) begin
						cnt <= cnt + 14'h0001;
					end
				end
				default: state <= pnlpc_pkg::PNLPC_SEQ_OFF;
			endcase
		end
	end

	// ***************************
	// Checks
	// ***************************
	property p_up_hold;
		@(posedge clk_sys) disable iff (!rst_n)
		(state == pnlpc_pkg::PNLPC_SEQ_UP && req && cnt < target) |=> !powered;
	endproperty
	a_up_hold: assert property (p_up_hold) else $error("power up ended early");

	property p_dn_hold;
		@(posedge clk_sys) disable iff (!rst_n)
		(state == pnlpc_pkg::PNLPC_SEQ_DOWN && cnt < target) |=> live;
	endproperty
	a_dn_hold: assert property (p_dn_hold) else $error("power down ended early");

	property p_load;
		@(posedge clk_sys) disable iff (!rst_n)
		(state == pnlpc_pkg::PNLPC_SEQ_OFF && req) |=> target == 14'($past(up_dly) * UP_STEP);
	endproperty
	a_load: assert property (p_load) else $error("wrong up delay loaded");

	property p_rise;
		@(posedge clk_sys) disable iff (!rst_n)
		$rose(powered);
	endproperty
	c_rise: cover property (p_rise);
endmodule
`default_nettype wire

// [test/pnlpc_panel_model.sv]
`default_nettype none
module pnlpc_panel_model (
	input wire pnlpc_pkg::pnlpc_pins_t pins,
	input wire logic gp_level,
	output logic general_io_one_pin,
	output logic panel_lit
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****
	// Backlight pin wire
	// ****
	// Panel side only drives the pin while the device lets go of it
	assign general_io_one_pin = pins.pin54_oe ? pins.pin54_out : gp_level;
	// Lit only with data driven plus bias and backlight both on
	assign panel_lit = pins.panel_oe & pins.pin61_out & pins.pin54_out;
endmodule
`default_nettype wire

// [test/testbench.sv]
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys, rst_n, io_wr, io_rd, sb_n, strap, gp_level, dac_en, text_mode, gp_out;
	logic [15:0] io_addr;
	logic [7:0] io_wdata, io_rdata, odc;
	logic [1:0] mpol;
	logic [2:0] rpl;
	logic gio_pin, gio_in, hstby, scr_en, pal_pd, pal_acc, sreq, lit;
	pnlpc_pkg::pnlpc_sig_t sig;
	pnlpc_pkg::pnlpc_pins_t pins;
	int mismatches, tests_run, cyc, n;
	// ****
	// Design and panel
	// ****
	// Short sequencing tick keeps the delays within a short run
	pnlpc_top #(.SEQ_DIV(4)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .io_addr(io_addr),
		.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
		.standby_pin_n(sb_n), .threshold_strap_pin(strap), .clk32_pin(1'b0),
		.general_io_one_pin(gio_pin), .seq_clk_32k_sel(1'b0), .dac_enabled(dac_en),
		.text_mode(text_mode), .misc_sync_pol(mpol), .general_io_one_out(gp_out),
		.sig_in(sig), .pins(pins), .general_io_one_in(gio_in), .output_drive_control(odc),
		.host_standby(hstby), .refresh_per_line(rpl), .screen_refresh_en(scr_en),
		.palette_powerdown(pal_pd), .palette_cpu_access(pal_acc), .standby_refresh_req(sreq));
	pnlpc_panel_model model (.pins(pins), .gp_level(gp_level), .general_io_one_pin(gio_pin),
		.panel_lit(lit));
	// ****
	// Helpers
	// ****
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		@(negedge clk_sys);
		io_addr = 16'h03d0;
		io_wdata = idx;
		io_wr = 1'b1;
		@(negedge clk_sys);
		io_addr = 16'h03d1;
		io_wdata = d;
		@(negedge clk_sys);
		io_wr = 1'b0;
		@(negedge clk_sys);
	endtask
	task automatic rc(input logic [7:0] idx, input logic [7:0] e);
		wr(8'h00, 8'h00);
		io_addr = 16'h03d0;
		io_wdata = idx;
		io_wr = 1'b1;
		@(negedge clk_sys);
		io_wr = 1'b0;
		io_rd = 1'b1;
		io_addr = 16'h03d1;
		@(negedge clk_sys);
		io_rd = 1'b0;
		chk($sformatf("reg_%h", idx), io_rdata, e);
	endtask
	task automatic tally_and_finish();
		$display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_reset();
		rc(8'h01, 8'h01);
		rc(8'h04, 8'h81);
		rc(8'h05, 8'h01);
		rc(8'h0c, 8'h00);
		chk("pulldown", {7'h0, pins.panel_pulldown}, 8'h01);
		chk("thresh", odc, 8'h02);
		wr(8'h0a, 8'h00);
		chk("thresh_wr", odc, 8'h00);
		wr(8'h06, 8'hff);
		rc(8'h06, 8'h07);
		wr(8'h02, 8'h5a);
		rc(8'h02, 8'h00);
		wr(8'h06, 8'h00);
	endtask
	task automatic t_sync();
		chk("sync", {6'h0, pins.hsync_out, pins.vsync_out}, 8'h03);
		wr(8'h0b, 8'h20);
		chk("simple_cs", {6'h0, pins.hsync_out, pins.vsync_out}, 8'h01);
		wr(8'h0b, 8'h04);
		chk("comp_sync", {6'h0, pins.hsync_out, pins.vsync_out}, 8'h01);
		wr(8'h0b, 8'h80);
		chk("memc", {7'h0, pins.mem_c_oe}, 8'h00);
		wr(8'h0b, 8'h00);
		chk("memc", {7'h0, pins.mem_c_oe}, 8'h01);
		dac_en = 1'b0;
		@(negedge clk_sys);
		@(negedge clk_sys);
		chk("dac_off", {6'h0, pins.hsync_out, pins.vsync_out}, 8'h00);
		wr(8'h06, 8'h04);
		chk("dac_keep", {6'h0, pins.hsync_out, pins.vsync_out}, 8'h03);
		dac_en = 1'b1;
		wr(8'h0c, 8'h40);
		chk("p54_cs", {6'h0, pins.pin54_oe, pins.pin54_out}, 8'h02);
		wr(8'h0c, 8'h80);
		repeat (4) @(negedge clk_sys);
		chk("p54_in", {6'h0, pins.pin54_oe, gio_in}, 8'h01);
		gp_out = 1'b1;
		wr(8'h0c, 8'hc0);
		chk("p54_out", {6'h0, pins.pin54_oe, pins.pin54_out}, 8'h03);
		wr(8'h0c, 8'h00);
	endtask
	task automatic t_panel();
		wr(8'h04, 8'h11);
		wr(8'h08, 8'h4e);
		mpol = 2'b10;
		wr(8'h01, 8'h02);
		n = 0;
		while (lit !== 1'b1 && n < 1000) begin
			@(negedge clk_sys);
			n++;
		end
		// 128 ticks of 4 clocks, give or take tick phase
		chk("up_dly", {7'h0, n >= 500 && n <= 530}, 8'h01);
		chk("alt_pol", {6'h0, pins.hsync_out, pins.vsync_out}, 8'h03);
		chk("pol", {5'h0, pins.frame_marker_out, pins.line_pulse_out, pins.ac_mod_out},
			8'h07);
		wr(8'h0b, 8'h03);
		chk("de_route", {5'h0, pins.frame_marker_out, pins.line_pulse_out, pins.ac_mod_out},
			8'h04);
		wr(8'h0b, 8'h00);
		wr(8'h08, 8'h6e);
		chk("gfx_inv", {7'h0, pins.video_invert}, 8'h01);
		text_mode = 1'b1;
		@(negedge clk_sys);
		@(negedge clk_sys);
		chk("txt_inv", {7'h0, pins.video_invert}, 8'h00);
		wr(8'h08, 8'h5e);
		chk("txt_inv", {7'h0, pins.video_invert}, 8'h01);
		wr(8'h01, 8'h01);
		@(negedge clk_sys);
		chk("bias_off", {7'h0, pins.pin61_out}, 8'h00);
		repeat (4150) @(negedge clk_sys);
		chk("dn_hold", {7'h0, pins.panel_oe}, 8'h01);
		repeat (300) @(negedge clk_sys);
		chk("dn_done", {7'h0, pins.panel_oe}, 8'h00);
		wr(8'h05, 8'h81);
		chk("crt_drv", {6'h0, pins.panel_oe, pins.panel_pulldown}, 8'h02);
	endtask
	task automatic t_standby();
		wr(8'h01, 8'h02);
		wr(8'h05, 8'h51);
		chk("hstby", {7'h0, hstby}, 8'h01);
		wr(8'h04, 8'h22);
		sb_n = 1'b0;
		repeat (4) @(negedge clk_sys);
		n = 0;
		repeat (40) begin
			@(negedge clk_sys);
			n += int'(sreq === 1'b1);
		end
		chk("stby_rfsh", {7'h0, n >= 9 && n <= 11}, 8'h01);
		chk("stby_sync", {6'h0, pins.hsync_out, pins.vsync_out}, 8'h00);
		sb_n = 1'b1;
		repeat (6) @(negedge clk_sys);
		chk("hstby_clr", {7'h0, hstby}, 8'h00);
		rc(8'h04, 8'h11);
		wr(8'h01, 8'h01);
	endtask
	task automatic t_poff();
		wr(8'h06, 8'h01);
		wr(8'h05, 8'h0f);
		chk("poff", {4'h0, scr_en, pal_pd, pal_acc, 1'b0}, 8'h04);
		chk("rfsh", {5'h0, rpl}, 8'h07);
		rc(8'h05, 8'h0f);
		wr(8'h06, 8'h03);
		chk("pal_acc", {7'h0, pal_acc}, 8'h01);
		wr(8'h05, 8'h01);
		chk("scr_on", {7'h0, scr_en}, 8'h01);
	endtask
	// ****
	// Run
	// ****
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc > 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	initial begin
		{rst_n, io_wr, io_rd, io_addr, io_wdata, text_mode, gp_out} = '0;
		{sb_n, strap, gp_level, dac_en} = 4'hf;
		mpol = 2'b01;
		sig = '{crt_hsync: 1'b0, crt_vsync: 1'b1, frame_marker: 1'b0, line_pulse: 1'b0,
			ac_mod: 1'b1, disp_en: 1'b1};
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (3) @(negedge clk_sys);
		t_reset();
		t_sync();
		t_panel();
		t_standby();
		t_poff();
		tally_and_finish();
	end
endmodule
`default_nettype wire
